// ---- bench/conv_src.sv ----
// Converter source model: conversion clock bursts and the core result word.
// Assumes busy from the port marks one conversion, all on mclk.
`timescale 1ns/10ps

module conv_src
    import adc_port_pkg::*;
#(
    parameter int HALF = 4,
    parameter int EDGES = 14
) (
    // Clock
    input wire logic mclk,
    // Port side
    input wire logic busy,
    output logic conversion_clock,
    output adc_port_pkg::conv_word_t core_result,
    // Bench side
    input wire adc_port_pkg::conv_word_t res_in
);
    int ph = 0;
    int left = 0;
    logic busy_d = 1'b0;
    logic clk_r = 1'b1;

    // Result word follows the bench setting
    assign core_result = res_in;

    // Clock idles high; an aborted burst still runs out its length
    assign conversion_clock = clk_r;

    // One burst of EDGES falling edges per conversion, slow phases
    always @(posedge mclk) begin
        busy_d <= busy;
        if (busy && !busy_d && left == 0) begin
            left <= 2 * EDGES;
            ph <= 0;
        end else if (left > 0) begin
            if (ph == HALF - 1) begin
                ph <= 0;
                clk_r <= ~clk_r;
                left <= left - 1;
            end else begin
                ph <= ph + 1;
            end
        end
    end
endmodule

// ---- bench/test_adc_parallel_port.sv ----
// Self-checking bench: host read and write tasks, directed sequences.
// Assumes the rtl files and the converter source model compile first.
`timescale 1ns/10ps

module test_adc_parallel_port;
    import adc_port_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    host_strobe_t strobes = 4'hf;
    logic [11:0] data_in = 12'h000;
    logic conversion_start_n = 1'b1;
    logic wr_to_shadow = 1'b0;
    conv_word_t res_in = 15'h0000;
    logic conversion_clock, busy, tracking, settled;
    conv_word_t core_result;
    logic [11:0] data_out, data_oe, control_word;
    logic [7:0] shadow_word;
    pwr_state_t pwr_state;
    int err_total = 0;
    int total_checks = 0;
    int k;

    // System clock, 10 ns period
    always #5 mclk = ~mclk;

    adc_parallel_port #(.WAKE_FULL_CYC(20), .WAKE_STBY_CYC(12)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .strobes(strobes),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .conversion_start_n(conversion_start_n),
        .conversion_clock(conversion_clock), .busy(busy),
        .core_result(core_result), .wr_to_shadow(wr_to_shadow),
        .control_word(control_word), .shadow_word(shadow_word),
        .pwr_state(pwr_state), .tracking(tracking), .settled(settled));

    conv_src src (.mclk(mclk), .busy(busy),
        .conversion_clock(conversion_clock),
        .core_result(core_result), .res_in(res_in));

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compare tasks, one per kind of result
    task automatic chk_w(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_p(input pwr_state_t got, input pwr_state_t exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t power got %b exp %b", $time, got, exp);
        end
    endtask

    // Let n edges pass, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Bounded wait on busy (0), tracking (1) or settled (2)
    task automatic wait_sig(input int which, input logic v, input int lim);
        int i;
        logic s;
        for (i = 0; i < lim; i++) begin
            tick(1);
            s = (which == 0) ? busy : (which == 1) ? tracking : settled;
            if (s === v) begin
                return;
            end
        end
        err_total++;
        $display("FAIL %0t wait ran out", $time);
        summarize();
    endtask

    // Host write: strobe low four cycles, data held well past the rise
    task automatic wr(input logic word, input logic [11:0] d);
        @(posedge mclk);
        strobes.word_mode <= word;
        data_in <= d;
        strobes.cs_n <= 1'b0;
        strobes.wr_n <= 1'b0;
        tick(3);
        @(posedge mclk);
        strobes.cs_n <= 1'b1;
        strobes.wr_n <= 1'b1;
        tick(8);
    endtask

    // Host read: compare driven lines, release, check three-state
    task automatic rd(input logic word, input logic sel,
                      input logic [11:0] exp);
        logic [11:0] m;
        m = word ? 12'hfff : 12'h0ff;
        @(posedge mclk);
        strobes.word_mode <= word;
        data_in <= {3'h0, sel, 8'h00};
        strobes.cs_n <= 1'b0;
        strobes.rd_n <= 1'b0;
        tick(5);
        chk_w(data_oe, m);
        chk_w(data_out & m, exp);
        @(posedge mclk);
        strobes.cs_n <= 1'b1;
        strobes.rd_n <= 1'b1;
        tick(6);
        chk_w(data_oe, 12'h000);
    endtask

    // One conversion; start stays low afterwards
    task automatic conv(input conv_word_t r);
        @(posedge mclk);
        res_in <= r;
        conversion_start_n <= 1'b0;
        wait_sig(0, 1'b1, 10);
        chk_b(tracking, 1'b0);
        wait_sig(0, 1'b0, 300);
    endtask

    task automatic start_set(input logic v);
        @(posedge mclk);
        conversion_start_n <= v;
    endtask

    // Main sequence
    initial begin
        tick(20);
        @(posedge mclk);
        sys_rst <= 1'b0;
        tick(2);
        chk_w(control_word, 12'h000);
        chk_p(pwr_state, ST_ON);
        chk_b(tracking, 1'b0);
        chk_w(data_oe, 12'h000);
        // A fall before the first rise starts nothing
        start_set(1'b0);
        tick(8);
        chk_b(busy, 1'b0);
        start_set(1'b1);
        wait_sig(1, 1'b1, 10);
        // Conversion, then reads in word and byte width
        conv({3'h5, 12'habc});
        start_set(1'b1);
        rd(1'b1, 1'b0, 12'habc);
        rd(1'b0, 1'b0, 12'h0bc);
        rd(1'b0, 1'b1, 12'h05a);
        // Select and read tied low across a conversion
        @(posedge mclk);
        strobes.word_mode <= 1'b1;
        strobes.cs_n <= 1'b0;
        strobes.rd_n <= 1'b0;
        tick(6);
        conv({3'h2, 12'h123});
        chk_w(data_out, 12'h123);
        chk_w(data_oe, 12'hfff);
        start_set(1'b1);
        @(posedge mclk);
        strobes.cs_n <= 1'b1;
        strobes.rd_n <= 1'b1;
        tick(6);
        // Control writes in word and byte width, then shadow
        wr(1'b1, 12'h8c3);
        chk_w(control_word, 12'h8c3);
        wr(1'b0, 12'h00f);
        chk_w(control_word, 12'h8c3);
        wr(1'b0, 12'h107);
        chk_w(control_word, 12'h70f);
        @(posedge mclk);
        wr_to_shadow <= 1'b1;
        wr(1'b0, 12'h0a5);
        chk_w({4'h0, shadow_word}, 12'h0a5);
        chk_w(control_word, 12'h70f);
        @(posedge mclk);
        wr_to_shadow <= 1'b0;
        // Auto shutdown then auto standby, start idling low
        for (k = 0; k < 2; k++) begin
            wr(1'b1, k ? 12'h020 : 12'h010);
            conv({3'h7, 12'h3c5});
            chk_p(pwr_state, k ? ST_STBY : ST_SHUT);
            chk_b(tracking, 1'b0);
            chk_b(settled, 1'b0);
            chk_w(control_word, k ? 12'h020 : 12'h010);
            start_set(1'b1);
            wait_sig(1, 1'b1, 10);
            wait_sig(2, 1'b1, 80);
        end
        // Full shutdown on the write, start ignored, woken by a write
        wr(1'b1, 12'h030);
        chk_p(pwr_state, ST_FULL);
        chk_b(tracking, 1'b0);
        start_set(1'b0);
        tick(8);
        chk_b(busy, 1'b0);
        start_set(1'b1);
        tick(8);
        chk_p(pwr_state, ST_FULL);
        wr(1'b1, 12'h000);
        chk_p(pwr_state, ST_ON);
        chk_b(tracking, 1'b1);
        wait_sig(2, 1'b1, 40);
        // Early return of start aborts the conversion
        start_set(1'b0);
        wait_sig(0, 1'b1, 10);
        tick(20);
        start_set(1'b1);
        wait_sig(0, 1'b0, 5);
        wait_sig(1, 1'b1, 5);
        tick(130);
        summarize();
    end
endmodule

// ---- rtl/adc_parallel_port.sv ----
// Parallel host port and power-mode control of an eight-channel converter.
// Assumes the host drives cs_n, rd_n, wr_n and data pins asynchronously,
// and the converter core presents its result on mclk before done.
//
// Functional notes
// - Word mode: one read gives twelve bits
// - Byte mode: two byte reads, pin eight selects
// - Low byte read drives eight result LSBs
// - High byte: MSBs, channel, then zero
// - Read active only while select and read low
// - Drive after both low, release after read
// - Tied-low read: new result before busy falls
// - Word write loads all twelve lines at once
// - Shadow register loads in one write
// - Write data captured on write rising edge
// - Two-bit power field, reset to normal
// - Hold after power-on until start rises
// - Code 01: shut down, hold after conversion
// - Code 10: standby, hold after conversion
// - Code 11: full shutdown on write edge
// - Leaving full shutdown powers up and tracks
// - Start falling edge begins conversion, busy high
// - Early start return aborts, back to track
`timescale 1ns/10ps
`include "adc_port_params.svh"

module adc_parallel_port
#(
    parameter int WAKE_FULL_CYC =
        (`WAKE_FULL_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int WAKE_STBY_CYC =
        (`WAKE_STBY_NS + `CLK_NS - 1) / `CLK_NS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Host strobes
    input wire adc_port_pkg::host_strobe_t strobes,
    // Data pins, bit 8 doubles as byte selector
    input wire logic [`RES_W-1:0] data_in,
    output logic [`RES_W-1:0] data_out,
    output logic [`RES_W-1:0] data_oe,
    // Conversion control pins
    input wire logic conversion_start_n,
    input wire logic conversion_clock,
    output logic busy,
    // Converter core side
    input wire adc_port_pkg::conv_word_t core_result,
    input wire logic wr_to_shadow,
    // Status
    output logic [`RES_W-1:0] control_word,
    output logic [`BYTE_W-1:0] shadow_word,
    output adc_port_pkg::pwr_state_t pwr_state,
    output logic tracking,
    output logic settled
);
    import adc_port_pkg::*;

    localparam int SYNC_W = `RES_W + 6;

    logic [SYNC_W-1:0] sync_q;
    logic [`RES_W-1:0] data_s;
    host_strobe_t strobe_s;
    logic cstart_s;
    logic cclk_s;
    logic cstart_d_r;
    logic cclk_d_r;
    logic wr_act_d_r;
    logic rd_act;
    logic wr_act;
    logic wr_rise;
    logic sel;
    logic cstart_fall;
    logic cstart_rise;
    logic cclk_fall;
    logic conv_go;
    logic conv_running;
    logic conv_done;
    logic done_d1_r;
    logic done_d2_r;
    logic [`BYTE_W-1:0] low_byte_r;
    logic ctrl_wr;
    logic [`RES_W-1:0] ctrl_nxt;
    power_code_t pm_nxt;
    power_code_t pm_cur;
    conv_word_t result_r;
    logic [19:0] wake_cnt_r;

    // Read data for the present mode and selector
    function automatic logic [`RES_W-1:0] read_mux(
        input logic word,
        input logic hi,
        input conv_word_t res
    );
        logic [`RES_W-1:0] v;
        v = '0;
        if (word) begin
            v = res.code;
        end else if (hi) begin
            v[7:0] = {1'b0, res.chan, res.code[11:8]};
        end else begin
            v[7:0] = res.code[7:0];
        end
        return v;
    endfunction

    // Power field of a control word
    function automatic power_code_t pm_of(input logic [`RES_W-1:0] w);
        return power_code_t'({w[`PM_HI_BIT], w[`PM_LO_BIT]});
    endfunction

    // All pins pass two flops before use
    pin_sync #(
        .W(SYNC_W),
        .RST_VAL({1'b0, 1'b1, 4'hf, {`RES_W{1'b0}}})
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .d({conversion_clock, conversion_start_n, strobes, data_in}),
        .q(sync_q)
    );

    // Split the synchronised pins
    assign data_s = sync_q[`RES_W-1:0];
    assign strobe_s = host_strobe_t'(sync_q[`RES_W+3:`RES_W]);
    assign cstart_s = sync_q[`RES_W+4];
    assign cclk_s = sync_q[`RES_W+5];
    assign sel = data_s[`SEL_BIT];

    // Qualified strobes and edges; a start counts only from track
    assign rd_act = !strobe_s.cs_n && !strobe_s.rd_n;
    assign wr_act = !strobe_s.cs_n && !strobe_s.wr_n;
    assign wr_rise = wr_act_d_r && !wr_act;
    assign cstart_fall = cstart_d_r && !cstart_s;
    assign cstart_rise = !cstart_d_r && cstart_s;
    assign cclk_fall = cclk_d_r && !cclk_s;
    assign conv_go = cstart_fall && tracking && !busy && pwr_state == ST_ON;
    assign pm_cur = pm_of(control_word);

    // Previous pin levels for edge detection
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cstart_d_r <= 1'b1;
            cclk_d_r <= 1'b0;
            wr_act_d_r <= 1'b0;
        end else begin
            cstart_d_r <= cstart_s;
            cclk_d_r <= cclk_s;
            wr_act_d_r <= wr_act;
        end
    end

    // Conversion edge counter
    conv_counter #(
        .EDGES(`CONV_EDGES)
    ) u_conv (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(conv_go),
        .abort(cstart_rise),
        .clk_fall(cclk_fall),
        .running(conv_running),
        .done(conv_done)
    );

    // Next control word from a write to the control register
    always_comb begin
        ctrl_wr = 1'b0;
        ctrl_nxt = control_word;
        if (wr_rise && !wr_to_shadow) begin
            if (strobe_s.word_mode) begin
                ctrl_wr = 1'b1;
                ctrl_nxt = data_s;
            end else if (sel) begin
                ctrl_wr = 1'b1;
                ctrl_nxt = {data_s[3:0], low_byte_r};
            end
        end
        pm_nxt = pm_of(ctrl_nxt);
    end

    // Control, low byte holding and shadow registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            control_word <= `CTRL_RST;
            low_byte_r <= 8'h00;
            shadow_word <= `SHADOW_RST;
        end else begin
            if (ctrl_wr) begin
                control_word <= ctrl_nxt;
            end
            if (wr_rise && !wr_to_shadow && !strobe_s.word_mode && !sel) begin
                low_byte_r <= data_s[7:0];
            end
            if (wr_rise && wr_to_shadow) begin
                shadow_word <= data_s[7:0];
            end
        end
    end

    // Result latch and busy; data is on the bus a cycle before busy falls
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_r <= '0;
            done_d1_r <= 1'b0;
            done_d2_r <= 1'b0;
            busy <= 1'b0;
        end else begin
            done_d1_r <= conv_done;
            done_d2_r <= done_d1_r;
            if (conv_done) begin
                result_r <= core_result;
            end
            if (conv_go) begin
                busy <= 1'b1;
            end else if (done_d2_r || (busy && !conv_running && !conv_done
                                       && !done_d1_r)) begin
                busy <= 1'b0;
            end
        end
    end

    // Bus drive while the read is qualified, released when it ends
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            data_out <= '0;
            data_oe <= '0;
        end else begin
            data_out <= read_mux(strobe_s.word_mode, sel, result_r);
            if (rd_act && strobe_s.word_mode) begin
                data_oe <= 12'hfff;
            end else if (rd_act) begin
                data_oe <= 12'h0ff;
            end else begin
                data_oe <= 12'h000;
            end
        end
    end

    // Power state and track-and-hold control
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pwr_state <= ST_ON;
            tracking <= 1'b0;
        end else if (ctrl_wr && pm_nxt == PM_FULL_DOWN) begin
            pwr_state <= ST_FULL;
            tracking <= 1'b0;
        end else if (ctrl_wr && pwr_state == ST_FULL) begin
            pwr_state <= ST_ON;
            tracking <= 1'b1;
        end else if (conv_go) begin
            tracking <= 1'b0;
        end else if (conv_done) begin
            case (pm_cur)
                PM_AUTO_SHUT: begin
                    pwr_state <= ST_SHUT;
                    tracking <= 1'b0;
                end
                PM_AUTO_STBY: begin
                    pwr_state <= ST_STBY;
                    tracking <= 1'b0;
                end
                default: begin
                    tracking <= pwr_state == ST_ON;
                end
            endcase
        end else if (cstart_rise) begin
            case (pwr_state)
                ST_SHUT, ST_STBY: begin
                    pwr_state <= ST_ON;
                    tracking <= 1'b1;
                end
                ST_ON: begin
                    tracking <= 1'b1;
                end
                default: begin
                    tracking <= tracking;
                end
            endcase
        end
    end

    // Power-up settling timer; settled shows the host may convert
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wake_cnt_r <= 20'h00000;
            settled <= 1'b1;
        end else if (ctrl_wr && pm_nxt == PM_FULL_DOWN) begin
            settled <= 1'b0;
        end else if (ctrl_wr && pwr_state == ST_FULL) begin
            wake_cnt_r <= 20'(WAKE_FULL_CYC - 1);
            settled <= 1'b0;
        end else if (conv_done && pm_cur != PM_NORMAL) begin
            settled <= 1'b0;
        end else if (cstart_rise && pwr_state == ST_SHUT) begin
            wake_cnt_r <= 20'(WAKE_FULL_CYC - 1);
        end else if (cstart_rise && pwr_state == ST_STBY) begin
            wake_cnt_r <= 20'(WAKE_STBY_CYC - 1);
        end else if (pwr_state == ST_ON && !settled) begin
            if (wake_cnt_r == 20'h00000) begin
                settled <= 1'b1;
            end else begin
                wake_cnt_r <= wake_cnt_r - 20'h00001;
            end
        end
    end

    // A qualified read drives the bus on the next edge
    read_drive_a: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_act |=> data_oe != 12'h000)
        else $error("read did not drive the bus");

    // The bus is released once the read ends
    read_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !rd_act |=> data_oe == 12'h000)
        else $error("bus still driven after read");

    // Byte mode high read carries MSBs, channel and a zero
    byte_high_a: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_act && !strobe_s.word_mode && sel |=>
        data_out[7:0] == {1'b0, $past(result_r.chan),
                          $past(result_r.code[11:8])} && data_oe == 12'h0ff)
        else $error("high byte read layout wrong");

    // Word read presents the full result
    word_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_act && strobe_s.word_mode |=> data_out == $past(result_r.code))
        else $error("word read data wrong");

    // New result reaches the bus before busy falls
    result_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
        conv_done |-> ##2 data_out == read_mux($past(strobe_s.word_mode),
                                               $past(sel), result_r) ##1 !busy)
        else $error("busy fell before result was on the bus");

    // Conversion start raises busy and holds the sample
    conv_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
        conv_go |=> busy && !tracking)
        else $error("start did not raise busy");

    // Full shutdown write powers down and holds
    full_down_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ctrl_wr && pm_nxt == PM_FULL_DOWN |=>
        pwr_state == ST_FULL && !tracking && !settled)
        else $error("full shutdown not entered");

    // Leaving full shutdown powers up and tracks
    full_wake_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ctrl_wr && pwr_state == ST_FULL && pm_nxt != PM_FULL_DOWN |=>
        pwr_state == ST_ON && tracking)
        else $error("full shutdown exit wrong");

    // Auto shutdown powers down at the end of conversion
    auto_down_a: assert property (@(posedge mclk) disable iff (sys_rst)
        conv_done && !ctrl_wr && pm_cur == PM_AUTO_SHUT |=>
        pwr_state == ST_SHUT && !tracking)
        else $error("auto shutdown not entered");

    // Standby wakes on the start rising edge
    stby_wake_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cstart_rise && pwr_state == ST_STBY && !ctrl_wr && !conv_done |=>
        pwr_state == ST_ON && tracking)
        else $error("standby wake failed");

endmodule

// ---- rtl/adc_port_params.svh ----
// Offsets, field positions, reset values and timing figures of the port.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

// Bus and word widths
`define RES_W 12
`define BYTE_W 8
`define CHAN_W 3
`define SEL_BIT 8

// Control word layout and reset value
`define CTRL_RST 12'h000
`define SHADOW_RST 8'h00
`define PM_LO_BIT 4
`define PM_HI_BIT 5

// Conversion clock falling edges in one conversion
`define CONV_EDGES 14

// Clock period and power-up times in nanoseconds
`define CLK_NS 10
`define WAKE_FULL_NS 10000000
`define WAKE_STBY_NS 600

`endif

// ---- rtl/adc_port_pkg.sv ----
// Types shared by the parallel port and its helpers.
// Assumes the params header sits beside it.
`include "adc_port_params.svh"

package adc_port_pkg;

    // Power field codes
    typedef enum logic [1:0] {
        PM_NORMAL = 2'b00,
        PM_AUTO_SHUT = 2'b01,
        PM_AUTO_STBY = 2'b10,
        PM_FULL_DOWN = 2'b11
    } power_code_t;

    // Power state of the converter
    typedef enum logic [1:0] {
        ST_ON = 2'b00,
        ST_SHUT = 2'b01,
        ST_STBY = 2'b10,
        ST_FULL = 2'b11
    } pwr_state_t;

    // Result from the converter core
    typedef struct packed {
        logic [`CHAN_W-1:0] chan;
        logic [`RES_W-1:0] code;
    } conv_word_t;

    // Host strobes, all active low except the width select
    typedef struct packed {
        logic word_mode;
        logic wr_n;
        logic rd_n;
        logic cs_n;
    } host_strobe_t;

endpackage

// ---- rtl/conv_counter.sv ----
// Counts conversion clock falling edges through one conversion.
// Assumes start, abort and clk_fall are one-cycle pulses on mclk.
`timescale 1ns/10ps
`include "adc_port_params.svh"

module conv_counter #(
    parameter int EDGES = `CONV_EDGES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control pulses
    input wire logic start,
    input wire logic abort,
    input wire logic clk_fall,
    // Status
    output logic running,
    output logic done
);

    logic [4:0] cnt_r;

    // Edge count; abort stops it without a done
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_r <= 5'h00;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !running) begin
                running <= 1'b1;
                cnt_r <= 5'h00;
            end else if (running && abort) begin
                running <= 1'b0;
            end else if (running && clk_fall) begin
                if (cnt_r == 5'(EDGES - 1)) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // Done only on the last edge of a full count
    conv_length_a: assert property (@(posedge mclk) disable iff (sys_rst)
        done |-> $past(cnt_r) == 5'(EDGES - 1) && $past(clk_fall))
        else $error("conversion ended on wrong edge count");

endmodule

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to mclk and individually sampled.
`timescale 1ns/10ps

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pins in, synchronised copy out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // First flop feeds only the second
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule
